/* File: hw/ccdc_pkg.sv */
// Package: constants for the clock output and converter control block
package ccdc_pkg;
    // ========================================
    // Control register bit positions
    localparam int CTRL_DSP_EN_BIT = 10;
    localparam int CTRL_CODEC_EN_BIT = 11;
    // ========================================
    // Output clock configuration cell bit positions
    localparam int OCC_BYPASS_BIT = 8;
    localparam int OCC_EXTRA_DIV2_BIT = 17;
    localparam logic [23:0] OCC_RESET = 24'h000000;
    // ========================================
    // Converter configuration bit positions (rectifier disables)
    localparam int CCFG_RECT1_DIS_BIT = 0;
    localparam int CCFG_RECT2_DIS_BIT = 8;
    localparam logic [15:0] CCFG_RESET = 16'h0000;
    // ========================================
    // Voltage target in 100 mV steps: 2.0 V .. 3.5 V, default 3.0 V
    localparam logic [5:0] VOLT_MIN = 6'h14;
    localparam logic [5:0] VOLT_MAX = 6'h23;
    localparam logic [5:0] VOLT_DEFAULT = 6'h1E;
    // Switching frequency in 10 kHz steps: 300 .. 580 kHz
    localparam logic [5:0] FREQ_MIN = 6'h1E;
    localparam logic [5:0] FREQ_MAX = 6'h3A;
    localparam logic [5:0] FREQ_RESET = 6'h1E;
    // Crystal rate in 10 kHz units, used to derive the switching divider
    localparam int XTAL_10KHZ = 1843;
    // ========================================
    // Sample rate classes
    typedef enum logic [1:0] {
        CCDC_FS_FULL,
        CCDC_FS_HALF,
        CCDC_FS_QUARTER
    } ccdc_fs_t;
    // Converter mode
    typedef enum logic {
        CCDC_MODE_PWM,
        CCDC_MODE_PFM
    } ccdc_mode_t;
endpackage

/* File: hw/ccdc_top.sv */
// Reference clock output and step-up converter control logic
// Functional notes
// - With DSP or codec enabled, clock output comes from synthesizer clock.
// - Scaler divides clock output by one, two or four by sample rate.
// - Divide 1 for 48/44.1/32, 2 for 24/22.05/16, 4 for 12/11.025/8 kHz.
// - Config bit 17 set adds a further divide by two.
// - Config bit 8 set bypasses the automatic scaler.
// - Config cell writes take effect only while DSP enable is set.
// - Divider settings stay in force after DSP is disabled.
// - Each converter target programmable 2.0 to 3.5 V; both reset to 3.0 V.
// - Enable pin high enables both; each also switchable by control.
// - PWM or PFM selectable per converter; PWM by default.
// - PWM clock from crystal; synchronised to codec clock when codec on.
// - PWM switching frequency selectable 300 to 580 kHz.
// - Crystal clock stops when no PWM converter and no other user.
// - Rectifier on when switch node above output, off at low current.
// - Disabled converter holds its P-channel rectifier on.
// - Converter config bits 8 and 0 disable the rectifier switches.
// - Enable pin from both-off starts converters in PWM at 3.0 V.
// - Power good rises when both nominal; falls when both 200 mV low.
`timescale 1ns/1ps
module ccdc_top #(
    parameter int VOLT_W = 6
) (
    // Clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    // Control register enables
    input wire logic DSP_EN_IN,
    input wire logic CODEC_EN_IN,
    // Clock path: synthesizer clock as sampled level, sample rate class
    input wire logic SYNTH_CLK_IN,
    input wire logic [1:0] FS_CLASS_IN,
    // Output clock configuration cell write
    input wire logic OCC_WR_IN,
    input wire logic [23:0] OCC_DATA_IN,
    // Converter control
    input wire logic CONV_ENABLE_PIN_IN,
    input wire logic [1:0] CONV_ON_SET_IN,
    input wire logic [1:0] CONV_OFF_SET_IN,
    input wire logic [1:0] CONV_PFM_IN,
    input wire logic [15:0] CONV_CFG_IN,
    input wire logic [VOLT_W-1:0] VOLT1_IN,
    input wire logic [VOLT_W-1:0] VOLT2_IN,
    input wire logic VOLT_WR_IN,
    input wire logic [5:0] FREQ_IN,
    input wire logic FREQ_WR_IN,
    input wire logic CODEC_CLK_IN,
    input wire logic OTHER_XTAL_USER_IN,
    // Analog comparator results, per converter
    input wire logic [1:0] NOMINAL_IN,
    input wire logic [1:0] UNDER_200MV_IN,
    input wire logic [1:0] SWNODE_ABOVE_IN,
    input wire logic [1:0] CURRENT_LOW_IN,
    // Outputs
    output logic REF_CLK_OUT,
    output logic [1:0] CONV_ACTIVE_OUT,
    output logic [1:0] CONV_PWM_OUT,
    output logic [VOLT_W-1:0] VOLT1_OUT,
    output logic [VOLT_W-1:0] VOLT2_OUT,
    output logic SW_CLK_OUT,
    output logic XTAL_RUN_OUT,
    output logic [1:0] RECT_ON_OUT,
    output logic POWER_GOOD_OUT
);
    // Targets and clamps are six bits wide; refuse any other width
    if (VOLT_W != 6) begin : g_volt_w_check
        $error("VOLT_W must be 6");
    end

    // ========================================
    // Helpers
    // Clamp a programmed value into its legal window
    function automatic logic [5:0] clamp6(input logic [5:0] v,
                                          input logic [5:0] lo,
                                          input logic [5:0] hi);
        if (v < lo) begin
            clamp6 = lo;
        end else if (v > hi) begin
            clamp6 = hi;
        end else begin
            clamp6 = v;
        end
    endfunction

    // ========================================
    // Clock output path
    logic bypass_reg;
    logic extra_div2_reg;
    logic [1:0] synth_d_reg;
    logic [2:0] div_cnt_reg;
    logic [2:0] div_cnt_next;
    logic [2:0] div_mask_reg;
    logic [2:0] div_mask_new;
    logic clk_active;
    logic synth_edge;

    // Config cell only written while DSP runs; held afterwards
    // DSP gated write
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            bypass_reg <= 1'b0;
            extra_div2_reg <= 1'b0;
        end else if (OCC_WR_IN && DSP_EN_IN) begin
            bypass_reg <= OCC_DATA_IN[ccdc_pkg::OCC_BYPASS_BIT];
            extra_div2_reg <= OCC_DATA_IN[ccdc_pkg::OCC_EXTRA_DIV2_BIT];
        end
    end

    // Division mask: count bits that must roll over per output toggle
    always_comb begin
        div_mask_new = 3'h0;
        if (!bypass_reg) begin
            case (FS_CLASS_IN)
                ccdc_pkg::CCDC_FS_HALF: div_mask_new = 3'h1;
                ccdc_pkg::CCDC_FS_QUARTER: div_mask_new = 3'h3;
                default: div_mask_new = 3'h0;
            endcase
        end
        if (extra_div2_reg) begin
            div_mask_new = {div_mask_new[1:0], 1'b1};
        end
    end

    assign clk_active = DSP_EN_IN || CODEC_EN_IN;
    // Both synth edges count, so ratio one passes the synth rate
    assign synth_edge = synth_d_reg[0] ^ synth_d_reg[1];
    assign div_cnt_next = div_cnt_reg + 3'h1;

    // Edge tracking of the synthesizer clock level
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            synth_d_reg <= 2'h0;
        end else begin
            synth_d_reg <= {synth_d_reg[0], SYNTH_CLK_IN};
        end
    end

    // Divider; a new ratio loads only when the count wraps or while the
    // output is stopped, so no shortened half period is ever produced
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            div_cnt_reg <= 3'h0;
            div_mask_reg <= 3'h0;
            REF_CLK_OUT <= 1'b0;
        end else if (!clk_active) begin
            div_cnt_reg <= 3'h0;
            div_mask_reg <= div_mask_new;
            REF_CLK_OUT <= 1'b0;
        end else if (synth_edge) begin
            if ((div_cnt_reg & div_mask_reg) == div_mask_reg) begin
                div_cnt_reg <= 3'h0;
                REF_CLK_OUT <= ~REF_CLK_OUT;
                div_mask_reg <= div_mask_new;
            end else begin
                div_cnt_reg <= div_cnt_next;
            end
        end
    end

    // ========================================
    // Converter enables, modes and targets

    // Enable pin turns both on; control sets and clears each one
    // enable sources
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            CONV_ACTIVE_OUT <= 2'h0;
        end else if (CONV_ENABLE_PIN_IN) begin
            CONV_ACTIVE_OUT <= 2'h3;
        end else begin
            CONV_ACTIVE_OUT <= (CONV_ACTIVE_OUT | CONV_ON_SET_IN)
                & ~CONV_OFF_SET_IN;
        end
    end

    // Start from both off restores defaults; otherwise control writes.
    // The pin level is used directly: a delayed edge would arrive after
    // the enables are already up and the defaults would be skipped.
    // mode select
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            CONV_PWM_OUT <= 2'h3;
            VOLT1_OUT <= ccdc_pkg::VOLT_DEFAULT;
            VOLT2_OUT <= ccdc_pkg::VOLT_DEFAULT;
        end else if (CONV_ENABLE_PIN_IN && CONV_ACTIVE_OUT == 2'h0) begin
            CONV_PWM_OUT <= 2'h3;
            VOLT1_OUT <= ccdc_pkg::VOLT_DEFAULT;
            VOLT2_OUT <= ccdc_pkg::VOLT_DEFAULT;
        end else begin
            CONV_PWM_OUT <= ~CONV_PFM_IN;
            if (VOLT_WR_IN) begin
                VOLT1_OUT <= clamp6(VOLT1_IN, ccdc_pkg::VOLT_MIN,
                                    ccdc_pkg::VOLT_MAX);
                VOLT2_OUT <= clamp6(VOLT2_IN, ccdc_pkg::VOLT_MIN,
                                    ccdc_pkg::VOLT_MAX);
            end
        end
    end

    // ========================================
    // PWM switching clock
    logic [5:0] freq_reg;
    logic [7:0] sw_cnt_reg;
    logic [7:0] sw_half;
    logic [1:0] codec_d_reg;
    logic codec_rise;

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            freq_reg <= ccdc_pkg::FREQ_RESET;
        end else if (FREQ_WR_IN) begin
            freq_reg <= clamp6(FREQ_IN, ccdc_pkg::FREQ_MIN,
                               ccdc_pkg::FREQ_MAX);
        end
    end

    // Half period in crystal ticks, counted directly as core clock cycles
    assign sw_half = 8'((ccdc_pkg::XTAL_10KHZ / 2) / int'(freq_reg));
    assign codec_rise = codec_d_reg[0] && !codec_d_reg[1];

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            codec_d_reg <= 2'h0;
        end else begin
            codec_d_reg <= {codec_d_reg[0], CODEC_CLK_IN};
        end
    end

    // Free running from crystal; restarts on codec edge when codec on
    // crystal and sync
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sw_cnt_reg <= 8'h00;
            SW_CLK_OUT <= 1'b0;
        end else if (!XTAL_RUN_OUT || CONV_PWM_OUT == 2'h0) begin
            sw_cnt_reg <= 8'h00;
            SW_CLK_OUT <= 1'b0;
        end else if (CODEC_EN_IN && codec_rise) begin
            sw_cnt_reg <= 8'h00;
            SW_CLK_OUT <= 1'b1;
        end else if (sw_cnt_reg + 8'h01 >= sw_half) begin
            sw_cnt_reg <= 8'h00;
            SW_CLK_OUT <= ~SW_CLK_OUT;
        end else begin
            sw_cnt_reg <= sw_cnt_reg + 8'h01;
        end
    end

    // Crystal only kept running while someone needs it
    // crystal gating
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            XTAL_RUN_OUT <= 1'b1;
        end else begin
            XTAL_RUN_OUT <= |(CONV_PWM_OUT & CONV_ACTIVE_OUT)
                || OTHER_XTAL_USER_IN || clk_active;
        end
    end

    // ========================================
    // Synchronous rectifiers
    // default control
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RECT_ON_OUT <= 2'h3;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!CONV_ACTIVE_OUT[i]) begin
                    RECT_ON_OUT[i] <= 1'b1;
                end else if (CONV_CFG_IN[i == 0 ? ccdc_pkg::CCFG_RECT1_DIS_BIT
                                        : ccdc_pkg::CCFG_RECT2_DIS_BIT]) begin
                    RECT_ON_OUT[i] <= 1'b0;
                end else if (SWNODE_ABOVE_IN[i]) begin
                    RECT_ON_OUT[i] <= 1'b1;
                end else if (CURRENT_LOW_IN[i]) begin
                    RECT_ON_OUT[i] <= 1'b0;
                end
            end
        end
    end

    // ========================================
    // Power good; comparators are asynchronous analog levels
    logic [1:0] nom_s1_reg;
    logic [1:0] nom_s2_reg;
    logic [1:0] low_s1_reg;
    logic [1:0] low_s2_reg;

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            nom_s1_reg <= 2'h0;
            nom_s2_reg <= 2'h0;
            low_s1_reg <= 2'h0;
            low_s2_reg <= 2'h0;
        end else begin
            nom_s1_reg <= NOMINAL_IN;
            nom_s2_reg <= nom_s1_reg;
            low_s1_reg <= UNDER_200MV_IN;
            low_s2_reg <= low_s1_reg;
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            POWER_GOOD_OUT <= 1'b0;
        end else if (nom_s2_reg == 2'h3) begin
            POWER_GOOD_OUT <= 1'b1;
        end else if (low_s2_reg == 2'h3) begin
            POWER_GOOD_OUT <= 1'b0;
        end
    end
endmodule

/* File: sim/ccdc_plant.sv */
// Behavioural model of synthesizer clock and converter comparators
`timescale 1ns/1ps
module ccdc_plant (
    // Clock
    input wire logic clk_in,
    // Converter state and fault injection
    input wire logic [1:0] active_in,
    input wire logic droop_in,
    // Synthesizer clock and comparator levels
    output logic synth_clk_out,
    output logic [1:0] nominal_out,
    output logic [1:0] under_out
);
    logic [1:0] ph_reg = 2'h0;
    logic [1:0] ramp_reg = 2'h0;
    // Quarter core rate, so the block can sample the synth clock
    always_ff @(negedge clk_in) begin
        ph_reg <= ph_reg + 2'h1;
    end
    assign synth_clk_out = ph_reg[1];
    // Output lags the enable; an idle converter only shows battery level
    always_ff @(negedge clk_in) begin
        ramp_reg <= active_in;
    end
    assign nominal_out = ramp_reg & ~{2{droop_in}};
    assign under_out = ~ramp_reg | {2{droop_in}};
endmodule

/* File: sim/ccdc_top_sva.sv */
// Checker for clock output and converter control ports
`timescale 1ns/1ps
module ccdc_chk #(
    parameter int VOLT_W = 6
) (
    // Clock, reset and enables
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic DSP_EN_IN,
    input wire logic CODEC_EN_IN,
    input wire logic CODEC_CLK_IN,
    input wire logic OTHER_XTAL_USER_IN,
    // Converter control and comparators
    input wire logic CONV_ENABLE_PIN_IN,
    input wire logic [1:0] CONV_OFF_SET_IN,
    input wire logic [1:0] CONV_PFM_IN,
    input wire logic [15:0] CONV_CFG_IN,
    input wire logic [1:0] NOMINAL_IN,
    input wire logic [1:0] UNDER_200MV_IN,
    // Outputs watched
    input wire logic REF_CLK_OUT,
    input wire logic [1:0] CONV_ACTIVE_OUT,
    input wire logic [1:0] CONV_PWM_OUT,
    input wire logic [VOLT_W-1:0] VOLT1_OUT,
    input wire logic XTAL_RUN_OUT,
    input wire logic SW_CLK_OUT,
    input wire logic [1:0] RECT_ON_OUT,
    input wire logic POWER_GOOD_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    // Crystal demand as seen from the registered state
    wire xneed = |(CONV_ACTIVE_OUT & CONV_PWM_OUT) | OTHER_XTAL_USER_IN
        | DSP_EN_IN | CODEC_EN_IN;
    sequence s_both_nom;
        (NOMINAL_IN == 2'b11)[*3];
    endsequence
    sequence s_both_low;
        (UNDER_200MV_IN == 2'b11 && NOMINAL_IN != 2'b11)[*3];
    endsequence
    sequence s_pin_quiet;
        (!CONV_ENABLE_PIN_IN)[*4];
    endsequence
    sequence s_codec_rise;
        $rose(CODEC_CLK_IN) && CODEC_EN_IN;
    endsequence
    sequence s_pwm_running;
        CODEC_EN_IN && XTAL_RUN_OUT && CONV_PWM_OUT != 2'b00;
    endsequence
    a_ref_clk_idle: assert property (
        (!DSP_EN_IN && !CODEC_EN_IN)[*3] |-> !REF_CLK_OUT)
        else $error("clock output runs while disabled");
    a_pin_enables: assert property (
        CONV_ENABLE_PIN_IN && CONV_OFF_SET_IN == 2'b00
        |=> CONV_ACTIVE_OUT == 2'b11)
        else $error("enable pin did not enable both");
    a_mode_follows: assert property (
        s_pin_quiet |=> CONV_PWM_OUT == ~$past(CONV_PFM_IN))
        else $error("mode does not follow selection");
    a_volt_range: assert property (
        VOLT1_OUT >= ccdc_pkg::VOLT_MIN && VOLT1_OUT <= ccdc_pkg::VOLT_MAX)
        else $error("voltage target out of range");
    a_xtal_gate: assert property (
        1'b1 |=> XTAL_RUN_OUT == $past(xneed))
        else $error("crystal gating wrong");
    a_rect_idle_on: assert property (
        !CONV_ACTIVE_OUT[0] |=> RECT_ON_OUT[0])
        else $error("idle rectifier not on");
    a_rect_disable: assert property (
        CONV_ACTIVE_OUT[1] && CONV_CFG_IN[8] |=> !RECT_ON_OUT[1])
        else $error("disabled rectifier is on");
    a_pgood_rise: assert property (
        s_both_nom |=> POWER_GOOD_OUT)
        else $error("power good did not rise");
    a_pgood_fall: assert property (
        s_both_low |=> !POWER_GOOD_OUT)
        else $error("power good did not fall");
    a_pgood_sync: assert property (
        $rose(POWER_GOOD_OUT) |-> $past(NOMINAL_IN, 3) == 2'b11)
        else $error("power good rose without synchronised cause");
    a_sw_sync: assert property (
        s_codec_rise ##1 s_pwm_running |=> SW_CLK_OUT)
        else $error("switching clock not restarted on codec edge");
endmodule
bind ccdc_top ccdc_chk #(.VOLT_W(VOLT_W)) u_ccdc_chk (
    .CORE_CLK_IN, .RST_IN, .DSP_EN_IN, .CODEC_EN_IN, .OTHER_XTAL_USER_IN,
    .CODEC_CLK_IN, .SW_CLK_OUT,
    .CONV_ENABLE_PIN_IN, .CONV_OFF_SET_IN, .CONV_PFM_IN, .CONV_CFG_IN,
    .NOMINAL_IN, .UNDER_200MV_IN, .REF_CLK_OUT, .CONV_ACTIVE_OUT,
    .CONV_PWM_OUT, .VOLT1_OUT, .XTAL_RUN_OUT, .RECT_ON_OUT, .POWER_GOOD_OUT);

/* File: sim/ccdc_top_bench.sv */
// Self-checking bench for the clock output and converter control
`timescale 1ns/1ps
module ccdc_top_bench;
    logic clk = 1'b0, rst = 1'b1, dsp = 1'b0, codec = 1'b0, occ_wr = 1'b0;
    logic pin = 1'b0, xuse = 1'b0, volt_wr = 1'b0, freq_wr = 1'b0;
    logic cclk = 1'b0, droop = 1'b0, synth, ref_clk, sw_clk, xrun, pgood;
    logic [1:0] fs = 2'h0, on_set = 2'h0, off_set = 2'h0, pfm = 2'h0;
    logic [1:0] swn = 2'h0, ilow = 2'h0, nom, und, act, pwm, rect;
    logic [5:0] v1 = 6'h1E, v2 = 6'h1E, fq = 6'h1E, vo1, vo2;
    logic [15:0] cfg = 16'h0000;
    logic [23:0] occ = 24'h000000;
    logic [31:0] lfsr = 32'h516169F3;
    int n_mismatch = 0, checked = 0, n;
    // Clocks; codec clock is slow and changes on core falling edges
    initial begin forever #50 clk = ~clk; end
    always #1300 cclk = ~cclk;
    ccdc_top u_ccdc_top (.CORE_CLK_IN(clk), .RST_IN(rst), .DSP_EN_IN(dsp),
        .CODEC_EN_IN(codec), .SYNTH_CLK_IN(synth), .FS_CLASS_IN(fs),
        .OCC_WR_IN(occ_wr), .OCC_DATA_IN(occ), .CONV_ENABLE_PIN_IN(pin),
        .CONV_ON_SET_IN(on_set), .CONV_OFF_SET_IN(off_set),
        .CONV_PFM_IN(pfm), .CONV_CFG_IN(cfg), .VOLT1_IN(v1), .VOLT2_IN(v2),
        .VOLT_WR_IN(volt_wr), .FREQ_IN(fq), .FREQ_WR_IN(freq_wr),
        .CODEC_CLK_IN(cclk), .OTHER_XTAL_USER_IN(xuse), .NOMINAL_IN(nom),
        .UNDER_200MV_IN(und), .SWNODE_ABOVE_IN(swn), .CURRENT_LOW_IN(ilow),
        .REF_CLK_OUT(ref_clk), .CONV_ACTIVE_OUT(act), .CONV_PWM_OUT(pwm),
        .VOLT1_OUT(vo1), .VOLT2_OUT(vo2), .SW_CLK_OUT(sw_clk),
        .XTAL_RUN_OUT(xrun), .RECT_ON_OUT(rect), .POWER_GOOD_OUT(pgood));
    ccdc_plant u_ccdc_plant (.clk_in(clk), .active_in(act),
        .droop_in(droop), .synth_clk_out(synth), .nominal_out(nom),
        .under_out(und));
    // ========================================
    // Helpers
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [5:0] clampv(logic [5:0] v);
        if (v < ccdc_pkg::VOLT_MIN) return ccdc_pkg::VOLT_MIN;
        if (v > ccdc_pkg::VOLT_MAX) return ccdc_pkg::VOLT_MAX;
        return v;
    endfunction
    // Switching half period in core cycles for a frequency code
    function automatic int sw_exp(logic [5:0] f);
        return (ccdc_pkg::XTAL_10KHZ / 2) / int'(f);
    endfunction
    // Half period in synth edges; class 3 behaves as full rate
    function automatic int ratio(logic [1:0] f, logic [23:0] c);
        int r;
        r = c[8] ? 1 : (f == 2'h1 ? 2 : (f == 2'h2 ? 4 : 1));
        return c[17] ? 2 * r : r;
    endfunction
    task automatic cyc(int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Cycles until the reference or switching clock next toggles; a stuck output ends the run
    task automatic half(input bit sw, output int k);
        logic last;
        k = 0;
        last = sw ? sw_clk : ref_clk;
        while ((sw ? sw_clk : ref_clk) === last && k < 200) begin
            cyc(1);
            k++;
        end
        if (k >= 200) begin
            n_mismatch++;
            final_report();
        end
    endtask
    task automatic pulse_volt();
        volt_wr = 1'b1;
        cyc(1);
        volt_wr = 1'b0;
        cyc(2);
    endtask
    // ========================================
    // Main sequence
    initial begin
        cyc(16);
        rst = 1'b0;
        cyc(1);
        chk("act", 2'h0, act);
        chk("pwm", 2'h3, pwm);
        chk("volt1", 6'h1E, vo1);
        chk("rect", 2'h3, rect);
        v1 = 6'h3F;
        v2 = 6'h01;
        pulse_volt();
        chk("volt2", clampv(v2), vo2);
        // Enable pin from both-off must restore default targets
        pin = 1'b1;
        cyc(4);
        pin = 1'b0;
        chk("act", 2'h3, act);
        chk("volt1", 6'h1E, vo1);
        for (int k = 0; k < 20 && pgood !== 1'b1; k++) cyc(1);
        chk("pgood", 24'h1, pgood);
        for (int i = 0; i < 8; i++) begin
            v1 = 6'(rnd());
            v2 = 6'(rnd());
            fq = ccdc_pkg::FREQ_MIN + 6'(rnd() % 29);
            freq_wr = 1'b1;
            pulse_volt();
            freq_wr = 1'b0;
            chk("volt1", clampv(v1), vo1);
            chk("volt2", clampv(v2), vo2);
        end
        // Switching clock at the last random rate, then an over-range code
        repeat (3) half(1'b1, n);
        chk("sw_half", sw_exp(fq), n);
        fq = 6'h3F;
        freq_wr = 1'b1;
        cyc(1);
        freq_wr = 1'b0;
        repeat (3) half(1'b1, n);
        chk("sw_clamp", sw_exp(ccdc_pkg::FREQ_MAX), n);
        droop = 1'b1;
        cyc(6);
        chk("pgood", 24'h0, pgood);
        droop = 1'b0;
        cfg = 16'h0101;
        cyc(2);
        chk("rect", 2'h0, rect);
        cfg = 16'h0000;
        swn = 2'h3;
        cyc(2);
        chk("rect", 2'h3, rect);
        swn = 2'h0;
        ilow = 2'h3;
        cyc(2);
        chk("rect", 2'h0, rect);
        ilow = 2'h0;
        pfm = 2'h3;
        cyc(3);
        chk("pwm", 2'h0, pwm);
        chk("xrun", 24'h0, xrun);
        xuse = 1'b1;
        cyc(2);
        chk("xrun", 24'h1, xrun);
        xuse = 1'b0;
        pfm = 2'h1;
        cyc(3);
        chk("xrun", 24'h1, xrun);
        off_set = 2'h1;
        cyc(1);
        off_set = 2'h0;
        cyc(2);
        chk("act", 2'h2, act);
        chk("rect", 2'h1, {1'b0, rect[0]});
        on_set = 2'h1;
        cyc(1);
        on_set = 2'h0;
        cyc(2);
        chk("act", 2'h3, act);
        // Every sample rate class against bypass and extra halving
        // host writes the cell only while the DSP runs
        dsp = 1'b1;
        for (int i = 0; i < 16; i++) begin
            fs = i[1:0];
            occ = {6'h00, i[3], 8'h00, i[2], 8'h00};
            occ_wr = 1'b1;
            cyc(1);
            occ_wr = 1'b0;
            repeat (3) half(1'b0, n);
            chk("ref_half", 2 * ratio(fs, occ), n);
        end
        codec = 1'b1;
        dsp = 1'b0;
        occ = 24'h000000;
        occ_wr = 1'b1;
        cyc(1);
        occ_wr = 1'b0;
        repeat (3) half(1'b0, n);
        chk("ref_held", 2 * ratio(fs, 24'h020100), n);
        // Codec clock is looked at on rising edges, where it is stable
        @(posedge clk);
        for (int k = 0; k < 40 && cclk !== 1'b0; k++) @(posedge clk);
        for (int k = 0; k < 40 && cclk !== 1'b1; k++) @(posedge clk);
        cyc(2);
        chk("sw_sync", 24'h1, sw_clk);
        codec = 1'b0;
        cyc(6);
        chk("ref_off", 24'h0, ref_clk);
        final_report();
    end
endmodule
